// File: verilog/pfc_pkg.sv
// Package: register map, field layout and type definitions for the feedback controller
package pfc_pkg;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_SETPOINT = 8'h04;
   localparam logic [7:0] REG_CENTER = 8'h08;
   localparam logic [7:0] REG_PGAIN = 8'h0C;
   localparam logic [7:0] REG_IGAIN = 8'h10;
   localparam logic [7:0] REG_DGAIN = 8'h14;
   localparam logic [7:0] REG_FLOOR = 8'h18;
   localparam logic [7:0] REG_CEIL = 8'h1C;
   localparam logic [7:0] REG_RATEDIV = 8'h20;
   localparam logic [7:0] REG_DTAU = 8'h24;
   localparam logic [7:0] REG_DEMOD = 8'h28;
   localparam logic [7:0] REG_STRDIV = 8'h2C;
   localparam logic [7:0] REG_ERROR = 8'h30;
   localparam logic [7:0] REG_SHIFT = 8'h34;
   localparam logic [7:0] REG_VALUE = 8'h38;
   localparam logic [7:0] REG_STATUS = 8'h3C;
   localparam logic [7:0] REG_ACHRATE = 8'h40;
   localparam logic [7:0] REG_LOCKTOL = 8'h44;
   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_KEEP_BIT = 1;
   localparam int CTRL_UNWRAP_BIT = 2;
   localparam int CTRL_MODE_LSB = 4;
   localparam int CTRL_INSEL_LSB = 8;
   localparam int CTRL_INCH_LSB = 12;
   localparam int CTRL_TGT_LSB = 16;
   localparam int CTRL_TGTCH_LSB = 20;
   localparam int CTRL_AUTO_LSB = 24;
   // Demod register fields
   localparam int DEM_ORDER_LSB = 0;
   localparam int DEM_HARM_LSB = 8;
   localparam int DEM_TAU_LSB = 16;
   localparam int DEM_SRC_LSB = 24;
   // Status bits
   localparam int STAT_LOCK_BIT = 0;
   localparam int STAT_OVF_BIT = 1;
   // ----------------------------------------
   // Reset values and limits
   // ----------------------------------------
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] DEMOD_RST = 32'h0000_0101;
   localparam logic [15:0] RATEDIV_RST = 16'h0001;
   localparam logic [15:0] STRDIV_RST = 16'h0001;
   localparam logic [3:0] ORDER_MIN = 4'h1;
   localparam logic [3:0] ORDER_MAX = 4'h8;
   localparam logic [3:0] SRC_MAX = 4'hB;
   localparam logic [2:0] TGT_MAX = 3'h4;
   localparam logic [15:0] LOCKTOL_RST = 16'h0100;
   localparam logic [5:0] GAIN_SHIFT = 6'h10;
   localparam logic [15:0] HALF_TURN = 16'h8000;
   localparam logic [31:0] STREAM_RATE_BASE = 32'h0773_5940;
   localparam logic [31:0] BUS_IDLE_DATA = 32'h0000_0000;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {MODE_PID, MODE_PLL, MODE_EXTREF, MODE_RSVD} pfc_mode_t;
   typedef enum logic [2:0] {IN_X, IN_Y, IN_R, IN_THETA, IN_AUXIN, IN_AUXOUT,
      IN_AUCART, IN_AUPOL} pfc_insel_t;
   typedef struct packed {
      logic [2:0] target;
      logic [2:0] channel;
      logic [31:0] value;
      logic valid;
   } pfc_drive_t;
   typedef struct packed {
      logic [31:0] error;
      logic [31:0] shift;
      logic [31:0] value;
      logic valid;
   } pfc_stream_t;
endpackage : pfc_pkg

// File: verilog/pfc_top.sv
// Feedback controller core with Avalon-MM register slave and decimated stream
`timescale 1ns/1ns
// How it works
// R01: Output is centre plus term, clamped
// R02: Error equals setpoint minus chosen input
// R03: Shift is P plus I plus D; shift_q holds the clamped output minus centre
// R04: Derivative low-pass, bypassed when tau zero
// R05: Retain or clear integral on disable
// R06: Input source code picks sample
// R07: Three modes: PID, PLL, external ref
// R08: Output target type code routing
// R09: Target instance index selects instance
// R10: Phase unwrap keeps tracking past wrap
// R11: Sample and update at controller rate
// R12: Loop runs only while enabled
// R13: Demod filter order one to eight
// R14: Read-only demod source indicator
// R15: Demod harmonic and time constant settings
// R16: Auto adaptation code zero to four
// R17: Lock flag in PLL mode
// R18: Stream decimated without touching controller
// R19: Report achieved stream rate
// R20: Sticky stream overflow flag
// R21: Output readable and streamed
// R22: Derivative from successive error difference
module pfc_top (
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   input wire logic [255:0] SRC_SAMPLES_I,
   input wire logic [3:0] DEMOD_SOURCE_I,
   input wire logic STREAM_READY_I,
   output pfc_pkg::pfc_drive_t DRIVE_O,
   output pfc_pkg::pfc_stream_t STREAM_O,
   output logic [3:0] DEMOD_ORDER_O,
   output logic [7:0] DEMOD_HARMONIC_O,
   output logic [7:0] DEMOD_TAU_O,
   output logic [2:0] AUTO_ADAPT_O
);
   import pfc_pkg::*;

   logic [31:0] ctrl_q, setpoint_q, center_q, pgain_q, igain_q, dgain_q;
   logic [31:0] floor_q, ceil_q, demod_q;
   logic [15:0] ratediv_q, strdiv_q, dtau_q, locktol_q;
   logic [15:0] rate_cnt_q, str_cnt_q;
   logic [31:0] error_q, shift_q, value_q, prev_err_q, dfilt_q;
   logic [47:0] integ_q;
   logic lock_q, ovf_q, tick_q, ack_q;
   logic [31:0] sel_sample;
   logic [3:0] src_s1_q, src_s2_q, src_s3_q, src_q;
   logic en, tick, str_tick;
   logic [31:0] err_d, dterm, dfilt_d, pterm, iterm, dout, sum, lo, hi, clamp_d;
   logic [47:0] integ_d;
   logic [31:0] raw_err;

   // Byte-enable merge of a write into a 32-bit register
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction : merge

   // Signed gain product scaled down to the data width
   function automatic logic [31:0] gmul(input logic [31:0] g, input logic [31:0] x);
      logic signed [63:0] p;
      p = $signed(g) * $signed(x);
      return p[47:16];
   endfunction : gmul

   assign en = ctrl_q[CTRL_EN_BIT];
   // ----------------------------------------
   // Register bus slave
   // ----------------------------------------
   logic wr_hit;
   // Write lands on the edge where the master sees waitrequest low
   assign wr_hit = AVS_WRITE_I && ack_q;

   // One wait cycle, then acknowledge
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (AVS_READ_I || AVS_WRITE_I) && !ack_q;
      end
   end
   assign AVS_WAITREQUEST_O = !ack_q;

   // Writable registers, stored on the acknowledge edge
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ctrl_q <= CTRL_RST;
         setpoint_q <= 32'h0000_0000;
         center_q <= 32'h0000_0000;
         pgain_q <= 32'h0000_0000;
         igain_q <= 32'h0000_0000;
         dgain_q <= 32'h0000_0000;
         floor_q <= 32'h0000_0000;
         ceil_q <= 32'h0000_0000;
         demod_q <= DEMOD_RST;
         ratediv_q <= RATEDIV_RST;
         strdiv_q <= STRDIV_RST;
         dtau_q <= 16'h0000;
         locktol_q <= LOCKTOL_RST;
      end else if (wr_hit) begin
         if (AVS_ADDRESS_I == REG_CTRL) begin
            ctrl_q <= merge(ctrl_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end else if (AVS_ADDRESS_I == REG_SETPOINT) begin
            setpoint_q <= merge(setpoint_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end else if (AVS_ADDRESS_I == REG_CENTER) begin
            center_q <= merge(center_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end else if (AVS_ADDRESS_I == REG_PGAIN) begin
            pgain_q <= merge(pgain_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end else if (AVS_ADDRESS_I == REG_IGAIN) begin
            igain_q <= merge(igain_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end else if (AVS_ADDRESS_I == REG_DGAIN) begin
            dgain_q <= merge(dgain_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end else if (AVS_ADDRESS_I == REG_FLOOR) begin
            floor_q <= merge(floor_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end else if (AVS_ADDRESS_I == REG_CEIL) begin
            ceil_q <= merge(ceil_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end else if (AVS_ADDRESS_I == REG_DEMOD) begin
            demod_q <= merge(demod_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
         end else if (AVS_ADDRESS_I == REG_RATEDIV) begin
            ratediv_q <= AVS_WRITEDATA_I[15:0];
         end else if (AVS_ADDRESS_I == REG_STRDIV) begin
            strdiv_q <= AVS_WRITEDATA_I[15:0];
         end else if (AVS_ADDRESS_I == REG_DTAU) begin
            dtau_q <= AVS_WRITEDATA_I[15:0];
         end else if (AVS_ADDRESS_I == REG_LOCKTOL) begin
            locktol_q <= AVS_WRITEDATA_I[15:0];
         end
      end
   end

   // Read data, valid on the acknowledge cycle; unmapped reads give zero
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         AVS_READDATA_O <= BUS_IDLE_DATA;
      end else if (AVS_READ_I && !ack_q) begin
         if (AVS_ADDRESS_I == REG_CTRL) begin
            AVS_READDATA_O <= ctrl_q;
         end else if (AVS_ADDRESS_I == REG_SETPOINT) begin
            AVS_READDATA_O <= setpoint_q;
         end else if (AVS_ADDRESS_I == REG_CENTER) begin
            AVS_READDATA_O <= center_q;
         end else if (AVS_ADDRESS_I == REG_PGAIN) begin
            AVS_READDATA_O <= pgain_q;
         end else if (AVS_ADDRESS_I == REG_IGAIN) begin
            AVS_READDATA_O <= igain_q;
         end else if (AVS_ADDRESS_I == REG_DGAIN) begin
            AVS_READDATA_O <= dgain_q;
         end else if (AVS_ADDRESS_I == REG_FLOOR) begin
            AVS_READDATA_O <= floor_q;
         end else if (AVS_ADDRESS_I == REG_CEIL) begin
            AVS_READDATA_O <= ceil_q;
         end else if (AVS_ADDRESS_I == REG_DEMOD) begin
            // R14: source indicator read-only
            AVS_READDATA_O <= {4'h0, src_q, demod_q[23:0]};
         end else if (AVS_ADDRESS_I == REG_RATEDIV) begin
            AVS_READDATA_O <= {16'h0000, ratediv_q};
         end else if (AVS_ADDRESS_I == REG_STRDIV) begin
            AVS_READDATA_O <= {16'h0000, strdiv_q};
         end else if (AVS_ADDRESS_I == REG_DTAU) begin
            AVS_READDATA_O <= {16'h0000, dtau_q};
         end else if (AVS_ADDRESS_I == REG_ERROR) begin
            AVS_READDATA_O <= error_q;
         end else if (AVS_ADDRESS_I == REG_SHIFT) begin
            AVS_READDATA_O <= shift_q;
         end else if (AVS_ADDRESS_I == REG_VALUE) begin
            AVS_READDATA_O <= value_q;
         end else if (AVS_ADDRESS_I == REG_STATUS) begin
            AVS_READDATA_O <= {30'h0000_0000, ovf_q, lock_q};
         end else if (AVS_ADDRESS_I == REG_ACHRATE) begin
            // R19: achieved rate from divider
            AVS_READDATA_O <= STREAM_RATE_BASE / {16'h0000, ratediv_q} / {16'h0000, strdiv_q};
         end else if (AVS_ADDRESS_I == REG_LOCKTOL) begin
            AVS_READDATA_O <= {16'h0000, locktol_q};
         end else begin
            AVS_READDATA_O <= BUS_IDLE_DATA;
         end
      end
   end

   // ----------------------------------------
   // Demodulator settings and source indicator
   // ----------------------------------------
   // Source code pin synchroniser, three stages
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         src_s1_q <= 4'h0;
         src_s2_q <= 4'h0;
         src_s3_q <= 4'h0;
         src_q <= 4'h0;
      end else begin
         src_s1_q <= DEMOD_SOURCE_I;
         src_s2_q <= src_s1_q;
         src_s3_q <= src_s2_q;
         // R14: only codes up to 11 accepted
         if (src_s2_q == src_s3_q && src_s3_q <= SRC_MAX) begin
            src_q <= src_s3_q;
         end
      end
   end

   // Settings to demodulator and adaptation logic
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         DEMOD_ORDER_O <= ORDER_MIN;
         DEMOD_HARMONIC_O <= 8'h01;
         DEMOD_TAU_O <= 8'h00;
         AUTO_ADAPT_O <= 3'h0;
      end else begin
         // R13: order clipped into 1..8
         if (demod_q[DEM_ORDER_LSB +: 4] < ORDER_MIN) begin
            DEMOD_ORDER_O <= ORDER_MIN;
         end else if (demod_q[DEM_ORDER_LSB +: 4] > ORDER_MAX) begin
            DEMOD_ORDER_O <= ORDER_MAX;
         end else begin
            DEMOD_ORDER_O <= demod_q[DEM_ORDER_LSB +: 4];
         end
         // R15: harmonic and time constant
         DEMOD_HARMONIC_O <= demod_q[DEM_HARM_LSB +: 8];
         DEMOD_TAU_O <= demod_q[DEM_TAU_LSB +: 8];
         // R16: adaptation code, held at 4 max
         AUTO_ADAPT_O <= (ctrl_q[CTRL_AUTO_LSB +: 3] > 3'h4) ? 3'h4 : ctrl_q[CTRL_AUTO_LSB +: 3];
      end
   end

   // ----------------------------------------
   // Controller datapath
   // ----------------------------------------
   // R11: update tick from rate divider
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I || !en) begin
         rate_cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else if (rate_cnt_q + 16'h0001 >= ratediv_q) begin
         rate_cnt_q <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         rate_cnt_q <= rate_cnt_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end
   // R12: loop advances only when enabled
   assign tick = tick_q && en;

   // R06: input code alone picks a sample; instance field unused
   assign sel_sample = SRC_SAMPLES_I[32*ctrl_q[CTRL_INSEL_LSB +: 3] +: 32];

   always_comb begin
      // R02: setpoint minus input
      raw_err = setpoint_q - sel_sample;
      err_d = raw_err;
      // R07: phase modes fold unless unwrapping; R10 keeps full range
      if (ctrl_q[CTRL_MODE_LSB +: 2] != 2'(MODE_PID) && !ctrl_q[CTRL_UNWRAP_BIT]) begin
         err_d = {{16{raw_err[15]}}, raw_err[15:0]};
      end
      // R22: successive difference times D gain
      dterm = gmul(dgain_q, err_d - prev_err_q);
      // R04: filter bypassed when tau zero
      if (dtau_q == 16'h0000) begin
         dfilt_d = dterm;
      end else begin
         dfilt_d = 32'($signed(dfilt_q) + ($signed(dterm - dfilt_q) >>> dtau_q[3:0]));
      end
      integ_d = integ_q + {{16{err_d[31]}}, err_d};
      // R03: P plus I plus D
      pterm = gmul(pgain_q, err_d);
      iterm = gmul(igain_q, integ_d[31:0]);
      dout = pterm + iterm + dfilt_d;
      // R01: centre added then clamped
      sum = center_q + dout;
      lo = center_q + floor_q;
      hi = center_q + ceil_q;
      if ($signed(sum) < $signed(lo)) begin
         clamp_d = lo;
      end else if ($signed(sum) > $signed(hi)) begin
         clamp_d = hi;
      end else begin
         clamp_d = sum;
      end
   end

   // Loop state updated on each tick
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         error_q <= 32'h0000_0000;
         shift_q <= 32'h0000_0000;
         value_q <= 32'h0000_0000;
         prev_err_q <= 32'h0000_0000;
         dfilt_q <= 32'h0000_0000;
      end else if (tick) begin
         error_q <= err_d;
         prev_err_q <= err_d;
         dfilt_q <= dfilt_d;
         value_q <= clamp_d;
         // R03: shift reported as output minus centre
         shift_q <= clamp_d - center_q;
      end
   end

   // Integrator, cleared on disable unless retained
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         integ_q <= 48'h0000_0000_0000;
      end else if (!en && !ctrl_q[CTRL_KEEP_BIT]) begin
         // R05: zeroed when disabled without retention
         integ_q <= 48'h0000_0000_0000;
      end else if (tick) begin
         integ_q <= integ_d;
      end
   end

   // R17: lock when PLL error inside tolerance
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         lock_q <= 1'b0;
      end else begin
         lock_q <= en && ctrl_q[CTRL_MODE_LSB +: 2] == 2'(MODE_PLL) &&
                   ($signed(error_q) <= $signed({16'h0000, locktol_q})) &&
                   ($signed(error_q) >= -$signed({16'h0000, locktol_q}));
      end
   end

   // R08: target type routing; R09: instance index
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         DRIVE_O <= '0;
      end else begin
         DRIVE_O.target <= (ctrl_q[CTRL_TGT_LSB +: 3] > TGT_MAX) ? TGT_MAX :
                           ctrl_q[CTRL_TGT_LSB +: 3];
         DRIVE_O.channel <= ctrl_q[CTRL_TGTCH_LSB +: 3];
         DRIVE_O.value <= clamp_d;
         DRIVE_O.valid <= tick;
      end
   end

   // ----------------------------------------
   // Stream decimation
   // ----------------------------------------
   assign str_tick = tick && (str_cnt_q + 16'h0001 >= strdiv_q);

   // R18: decimation counter, controller untouched
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         str_cnt_q <= 16'h0000;
      end else if (str_tick) begin
         str_cnt_q <= 16'h0000;
      end else if (tick) begin
         str_cnt_q <= str_cnt_q + 16'h0001;
      end
   end

   // R21: value streamed with error and shift
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         STREAM_O <= '0;
      end else if (str_tick) begin
         STREAM_O <= '{error: err_d, shift: clamp_d - center_q, value: clamp_d, valid: 1'b1};
      end else if (STREAM_READY_I) begin
         STREAM_O.valid <= 1'b0;
      end
   end

   // R20: sticky overflow, cleared by writing status
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ovf_q <= 1'b0;
      end else if (str_tick && STREAM_O.valid && !STREAM_READY_I) begin
         ovf_q <= 1'b1;
      end else if (wr_hit && AVS_ADDRESS_I == REG_STATUS && AVS_WRITEDATA_I[STAT_OVF_BIT]) begin
         ovf_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence bus_req_s;
      (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
   endsequence
   sequence bus_ack_s;
      !AVS_WAITREQUEST_O;
   endsequence

   bus_answer_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // bus handshake, one wait cycle
      bus_req_s |=> bus_ack_s) else $error("bus request not answered next cycle");
   clamp_range_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R01
      tick |=> ($signed(value_q) >= $signed($past(lo)) ||
      $signed($past(floor_q)) > $signed($past(ceil_q)))) else $error("output below floor");
   shift_rel_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R03
      tick |=> shift_q == value_q - $past(center_q)) else $error("shift mismatch");
   error_rel_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R02
      tick && ctrl_q[CTRL_MODE_LSB +: 2] == 2'(MODE_PID) |=> error_q == $past(raw_err))
      else $error("error not setpoint minus input");
   integ_clear_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R05
      !en && !ctrl_q[CTRL_KEEP_BIT] |=> integ_q == 48'h0000_0000_0000)
      else $error("integral kept while disabled");
   idle_hold_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R12
      !en [*2] |-> $stable(value_q)) else $error("output moved while disabled");
   lock_mode_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R17
      lock_q |-> $past(ctrl_q[CTRL_MODE_LSB +: 2]) == 2'(MODE_PLL))
      else $error("lock outside PLL mode");
   ovf_sticky_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R20
      ovf_q && !(wr_hit && AVS_ADDRESS_I == REG_STATUS) |=> ovf_q)
      else $error("overflow flag dropped");
   stream_tick_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R18
      str_tick |=> STREAM_O.valid && STREAM_O.value == value_q)
      else $error("stream sample mismatch");
   order_range_a: assert property (@(posedge MCLK_I) disable iff (SYS_RST_I) // R13
      DEMOD_ORDER_O >= ORDER_MIN && DEMOD_ORDER_O <= ORDER_MAX) else $error("bad order");
endmodule : pfc_top

// File: sim/pfc_host_model.sv
// Host-side stream consumer model for the feedback controller
`timescale 1ns/1ns
module pfc_host_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic stall_i,
   input wire pfc_pkg::pfc_stream_t stream_i,
   output logic ready_o,
   output logic [15:0] taken_o
);
   import pfc_pkg::*;
   assign ready_o = !stall_i;
   // Count samples handed over
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         taken_o <= 16'h0000;
      end else if (stream_i.valid && ready_o) begin
         taken_o <= taken_o + 16'h0001;
      end
   end
endmodule : pfc_host_model

// File: sim/tb_top.sv
// Self-checking bench for the feedback controller
`timescale 1ns/1ns
module tb_top;
   import pfc_pkg::*;
   logic MCLK_I = 1'b0;
   logic SYS_RST_I = 1'b1;
   logic [7:0] addr = 8'h00;
   logic rd_en = 1'b0, wr_en = 1'b0, stall = 1'b0, waitreq, ready;
   logic [31:0] wdata = 32'h0, rdata, got;
   logic [255:0] samples = '0;
   logic [15:0] taken;
   logic [3:0] order, src_code = 4'hA;
   logic [7:0] harm, tau;
   logic [2:0] auto_sel;
   pfc_drive_t drive;
   pfc_stream_t stream;
   int failures = 0, cmp_count = 0, cycles = 0;

   pfc_top dut (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .AVS_ADDRESS_I(addr),
      .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata),
      .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
      .SRC_SAMPLES_I(samples), .DEMOD_SOURCE_I(src_code), .STREAM_READY_I(ready),
      .DRIVE_O(drive), .STREAM_O(stream), .DEMOD_ORDER_O(order),
      .DEMOD_HARMONIC_O(harm), .DEMOD_TAU_O(tau), .AUTO_ADAPT_O(auto_sel));
   pfc_host_model host (.clk_i(MCLK_I), .rst_i(SYS_RST_I), .stall_i(stall),
      .stream_i(stream), .ready_o(ready), .taken_o(taken));

   // Clock and cycle ceiling
   initial begin
      forever #4 MCLK_I = ~MCLK_I;
   end
   always @(posedge MCLK_I) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         results();
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic results;
      $display("checks %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : results
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] val);
      cmp_count++;
      if (val !== exp) begin
         $display("mismatch %s expected %h seen %h", nm, exp, val);
         failures++;
      end
   endtask : chk
   // Avalon cycle, held until waitrequest sampled low
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge MCLK_I);
      addr <= a;
      wr_en <= w;
      rd_en <= !w;
      wdata <= d;
      do begin
         @(posedge MCLK_I);
         n++;
      end while (waitreq !== 1'b0 && n < 64);
      got = rdata;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      chk("bus ack", 32'h1, {31'h0, n < 64});
   endtask : bus
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk(nm, exp, got);
   endtask : rd
   task automatic wait_drive;
      int n;
      n = 0;
      @(posedge MCLK_I);
      while (drive.valid !== 1'b1 && n < 64) begin
         @(posedge MCLK_I);
         n++;
      end
      chk("update seen", 32'h1, {31'h0, n < 64});
   endtask : wait_drive
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      rd("ctrl", REG_CTRL, CTRL_RST);
      rd("demod", REG_DEMOD, DEMOD_RST | 32'h0A00_0000);
      rd("unmapped", 8'h80, BUS_IDLE_DATA);
      chk("order", {28'h0, ORDER_MIN}, {28'h0, order});
      bus(REG_SETPOINT, 1'b1, 32'h0000_1000);
      bus(REG_CENTER, 1'b1, 32'h0000_0100);
      bus(REG_PGAIN, 1'b1, 32'h0001_0000);
      bus(REG_FLOOR, 1'b1, 32'h8000_0000);
      bus(REG_CEIL, 1'b1, 32'h0FFF_FFFF);
      $display("test reset done");
   endtask : t_reset
   task automatic t_route;
      logic [31:0] err;
      for (int k = 0; k < 8; k++) begin
         err = 32'h1000 - 32'h100 * (k + 1);
         bus(REG_CTRL, 1'b1, 32'h1 | k << 8 | (k % 5) << 16 | k << 20 | (k % 5) << 24);
         wait_drive();
         wait_drive();
         chk("target", k % 5, {29'h0, drive.target});
         chk("channel", k, {29'h0, drive.channel});
         chk("drive", err + 32'h100, drive.value);
         chk("auto", k % 5, {29'h0, auto_sel});
         rd("error", REG_ERROR, err);
         rd("value", REG_VALUE, err + 32'h100);
      end
      $display("test route done");
   endtask : t_route
   task automatic t_clamp;
      bus(REG_CEIL, 1'b1, 32'h0000_0010);
      wait_drive();
      wait_drive();
      chk("ceil drive", 32'h110, drive.value);
      rd("ceil shift", REG_SHIFT, 32'h10);
      bus(REG_SETPOINT, 1'b1, 32'h0);
      bus(REG_FLOOR, 1'b1, 32'hFFFF_FFE0);
      wait_drive();
      wait_drive();
      rd("floor value", REG_VALUE, 32'hE0);
      $display("test clamp done");
   endtask : t_clamp
   task automatic t_stream;
      int seen;
      seen = 0;
      stall <= 1'b1;
      src_code <= 4'hB;
      wait_drive();
      wait_drive();
      rd("ovf set", REG_STATUS, 32'h2);
      bus(REG_CTRL, 1'b1, 32'h0);
      stall <= 1'b0;
      // Last update before the disable drains
      @(posedge MCLK_I);
      repeat (20) begin
         @(posedge MCLK_I);
         seen += drive.valid;
      end
      chk("idle updates", 32'h0, seen);
      chk("stream error", 32'hFFFF_F800, stream.error);
      chk("stream shift", 32'hFFFF_FFE0, stream.shift);
      chk("stream value", 32'h0000_00E0, stream.value);
      bus(REG_STATUS, 1'b1, 32'h2);
      rd("ovf clear", REG_STATUS, 32'h0);
      chk("taken", 32'h1, {31'h0, taken != 16'h0});
      rd("rate", REG_ACHRATE, STREAM_RATE_BASE);
      bus(REG_STRDIV, 1'b1, 32'h5);
      rd("rate div", REG_ACHRATE, 32'd25000000);
      bus(REG_DEMOD, 1'b1, 32'h0005_0308);
      rd("demod rb", REG_DEMOD, 32'h0B05_0308);
      chk("dem out", 32'h080305, {12'h0, order, harm, tau});
      $display("test stream done");
   endtask : t_stream

   task automatic t_pll;
      src_code <= 4'hC;
      bus(REG_SETPOINT, 1'b1, 32'h0001_0050);
      bus(REG_CTRL, 1'b1, 32'h0000_0711);
      wait_drive();
      wait_drive();
      rd("fold error", REG_ERROR, 32'hFFFF_F850);
      bus(REG_CTRL, 1'b1, 32'h0000_0715);
      wait_drive();
      wait_drive();
      rd("unwrap error", REG_ERROR, 32'h0000_F850);
      bus(REG_SETPOINT, 1'b1, 32'h0000_0850);
      wait_drive();
      wait_drive();
      rd("lock", REG_STATUS, 32'h1);
      rd("src refused", REG_DEMOD, 32'h0B05_0308);
      $display("test pll done");
   endtask : t_pll

   // Main sequence
   initial begin
      for (int k = 0; k < 8; k++) begin
         samples[32 * k +: 32] = 32'h100 * (k + 1);
      end
      repeat (4) @(posedge MCLK_I);
      SYS_RST_I <= 1'b0;
      t_reset();
      t_route();
      t_clamp();
      t_stream();
      t_pll();
      results();
   end
endmodule : tb_top
